// [hw/crfs_top.sv]
// clock resource selection, compatibility clock programming and fallback selection
//
// Summary of operation
// - primary source 00 ext ref, 01 resource divider, 10 DPLL 2.048, 11 DPLL 4.096
// - pll1 bypass 0 runs first PLL, 1 passes its input straight through
// - pll1 rate select picks multiplier 16 or 32
// - pll2 bypass 0 runs second PLL, 1 bypasses it
// - pll2 rate select picks multiplier 8 or 16
// - compat clock field 00 puts both compatibility outputs in high impedance
// - 01 gives 2.048/4.096 MHz, 10 gives 4.096/8.192 MHz
// - 11 gives 8.192 MHz and a phase shifted 8.192 MHz double clock
// - fallback source uses the primary decode and feeds first PLL under forced or type 10 fallback
// - force fallback applies fallback source and sync whatever the failures and the type
// - fallback sync field picks the sync source once forced or type 10 fallback is in effect
// - type 00 osc/4 on main failure, 01 none, 10 secondary plus state machine
// - sync 000 osc/4, 001 osc, 010 A, 011 B, upper netref or locals
`timescale 1ns/1ps
module crfs_top
    import crfs_pkg::*;
(
    // clock and reset
    input  wire logic                CLOCK,
    input  wire logic                RST_N,
    // wishbone slave
    input  wire logic                CYC_I,
    input  wire logic                STB_I,
    input  wire logic                WE_I,
    input  wire logic [7:0]          ADR_I,
    input  wire logic [3:0]          SEL_I,
    input  wire logic [31:0]         DAT_I,
    output logic      [31:0]         DAT_O,
    output logic                     ACK_O,
    // failure detector and main sync selection
    input  wire logic                MAIN_CLOCK_FAIL,
    input  wire logic                AB_CLOCK_FAIL,
    input  wire logic [2:0]          MAIN_SYNC_SEL,
    // clocking controls
    output crfs_pll_type             PLL_CTRL,
    output crfs_compat_type          COMPAT_CTRL,
    output logic [2:0]               SYNC_SEL,
    output logic                     FALLBACK_ACTIVE,
    output logic                     FALLBACK_SM_ENABLE
);

    logic [7:0]  resource_reg;
    logic [7:0]  secondary_reg;
    logic        fail_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [7:0]  word_idx;
    logic        wr_strobe;
    logic        clear_fail;

    crfs_fb_type  fb_type;
    logic         force_fb;
    logic         use_secondary;
    logic         use_osc_div4;

    crfs_pll_type    pll_next;
    crfs_compat_type compat_next;
    logic [2:0]      sync_next;

    function automatic logic [5:0] pick_mult(input logic hi, input logic [5:0] lo_v,
                                            input logic [5:0] hi_v);
        pick_mult = hi ? hi_v : lo_v;
    endfunction

    assign word_idx  = {2'b00, ADR_I[7:2]};
    // one write per bus cycle: taken on the edge that raises ack
    assign wr_strobe = CYC_I && STB_I && WE_I && !ack_reg && SEL_I[0];
    assign clear_fail = wr_strobe && (word_idx == CRFS_IDX_STATUS) &&
                        DAT_I[CRFS_ST_FAIL_BIT];

    // register writes; new settings drive outputs from the next edge
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            resource_reg  <= CRFS_RESOURCE_RESET;
            secondary_reg <= CRFS_SECONDARY_RESET;
        end else if (wr_strobe) begin
            if (word_idx == CRFS_IDX_RESOURCE) begin
                resource_reg <= DAT_I[7:0];
            end
            if (word_idx == CRFS_IDX_SECONDARY) begin
                secondary_reg <= DAT_I[7:0];
            end
        end
    end

    // bus answer: one wait state, ack drops the cycle after it is given
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= CYC_I && STB_I && !ack_reg;
            case (word_idx)
                CRFS_IDX_RESOURCE:  rdata_reg <= {24'h00_0000, resource_reg};
                CRFS_IDX_SECONDARY: rdata_reg <= {24'h00_0000, secondary_reg};
                CRFS_IDX_STATUS:    rdata_reg <= {30'h0000_0000, fail_reg, FALLBACK_ACTIVE};
                default:            rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign ACK_O = ack_reg;
    assign DAT_O = rdata_reg;

    assign fb_type  = crfs_fb_type'(secondary_reg[CRFS_FB_TYPE_LSB +: 2]);
    assign force_fb = secondary_reg[CRFS_FORCE_BIT];

    // sticky failure; a failure in the clearing cycle wins over the clear
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            fail_reg <= 1'b0;
        end else if ((fb_type == CRFS_FB_OSC_DIV4 && MAIN_CLOCK_FAIL) ||
                     (fb_type == CRFS_FB_SECONDARY && AB_CLOCK_FAIL)) begin
            fail_reg <= 1'b1;
        end else if (clear_fail) begin
            fail_reg <= 1'b0;
        end
    end

    // type 00 only free-runs on osc/4 and leaves the source mux alone
    always_comb begin
        use_secondary = force_fb || (fb_type == CRFS_FB_SECONDARY && fail_reg);
        use_osc_div4  = !force_fb && fb_type == CRFS_FB_OSC_DIV4 && fail_reg;
    end

    always_comb begin
        pll_next.pll1_source_sel = use_secondary ?
            crfs_src_type'(secondary_reg[CRFS_FB_SRC_LSB +: 2]) :
            crfs_src_type'(resource_reg[CRFS_PLL1_SRC_LSB +: 2]);
        pll_next.pll1_bypass = resource_reg[CRFS_PLL1_BYP_BIT];
        pll_next.pll1_mult   = pick_mult(resource_reg[CRFS_PLL1_RATE_BIT],
                                         CRFS_PLL1_MULT_LO, CRFS_PLL1_MULT_HI);
        pll_next.pll2_bypass = resource_reg[CRFS_PLL2_BYP_BIT];
        pll_next.pll2_mult   = pick_mult(resource_reg[CRFS_PLL2_RATE_BIT],
                                         CRFS_PLL2_MULT_LO, CRFS_PLL2_MULT_HI);
    end

    always_comb begin
        compat_next.drive_n        = 1'b0;
        compat_next.bit_khz        = CRFS_KHZ_2048;
        compat_next.double_khz     = CRFS_KHZ_4096;
        compat_next.double_shifted = 1'b0;
        case (crfs_cmp_type'(resource_reg[CRFS_COMPAT_LSB +: 2]))
            CRFS_CMP_OFF: begin
                compat_next.drive_n    = 1'b1;
                compat_next.bit_khz    = 14'd0;
                compat_next.double_khz = 14'd0;
            end
            CRFS_CMP_2M: begin
                compat_next.bit_khz    = CRFS_KHZ_2048;
                compat_next.double_khz = CRFS_KHZ_4096;
            end
            CRFS_CMP_4M: begin
                compat_next.bit_khz    = CRFS_KHZ_4096;
                compat_next.double_khz = CRFS_KHZ_8192;
            end
            CRFS_CMP_8M_SHIFT: begin
                compat_next.bit_khz        = CRFS_KHZ_8192;
                compat_next.double_khz     = CRFS_KHZ_8192;
                compat_next.double_shifted = 1'b1;
            end
            default: begin
                compat_next.drive_n = 1'b1;
            end
        endcase
    end

    // sync source codes pass through unchanged; downstream decodes them
    always_comb begin
        if (use_secondary) begin
            sync_next = secondary_reg[CRFS_FB_SYNC_LSB +: 3];
        end else if (use_osc_div4) begin
            sync_next = CRFS_SYNC_OSC_DIV4;
        end else begin
            sync_next = MAIN_SYNC_SEL;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            PLL_CTRL           <= '0;
            COMPAT_CTRL        <= '{drive_n: 1'b1, bit_khz: 14'd0, double_khz: 14'd0,
                                    double_shifted: 1'b0};
            SYNC_SEL           <= CRFS_SYNC_OSC_DIV4;
            FALLBACK_ACTIVE    <= 1'b0;
            FALLBACK_SM_ENABLE <= 1'b0;
        end else begin
            PLL_CTRL           <= pll_next;
            COMPAT_CTRL        <= compat_next;
            SYNC_SEL           <= sync_next;
            FALLBACK_ACTIVE    <= use_secondary || use_osc_div4;
            FALLBACK_SM_ENABLE <= (fb_type == CRFS_FB_SECONDARY);
        end
    end

endmodule

// [hw/crfs_pkg.sv]
// package: register map, field layout, decodes and carriers for the clock resource/fallback select
package crfs_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] CRFS_IDX_RESOURCE  = 8'h03;
    localparam logic [7:0] CRFS_IDX_SECONDARY = 8'h04;
    localparam logic [7:0] CRFS_IDX_STATUS    = 8'h08;

    localparam logic [7:0] CRFS_RESOURCE_RESET  = 8'h00;
    localparam logic [7:0] CRFS_SECONDARY_RESET = 8'h00;

    // clock_resource_select fields
    localparam int CRFS_PLL1_SRC_LSB  = 6;
    localparam int CRFS_PLL1_BYP_BIT  = 5;
    localparam int CRFS_PLL1_RATE_BIT = 4;
    localparam int CRFS_PLL2_BYP_BIT  = 3;
    localparam int CRFS_PLL2_RATE_BIT = 2;
    localparam int CRFS_COMPAT_LSB    = 0;

    // secondary_clock_select fields
    localparam int CRFS_FB_SRC_LSB   = 6;
    localparam int CRFS_FB_TYPE_LSB  = 4;
    localparam int CRFS_FORCE_BIT    = 3;
    localparam int CRFS_FB_SYNC_LSB  = 0;

    // status register bits
    localparam int CRFS_ST_ACTIVE_BIT = 0;
    localparam int CRFS_ST_FAIL_BIT   = 1;

    // rate multipliers
    localparam logic [5:0] CRFS_PLL1_MULT_LO = 6'h10;
    localparam logic [5:0] CRFS_PLL1_MULT_HI = 6'h20;
    localparam logic [5:0] CRFS_PLL2_MULT_LO = 6'h08;
    localparam logic [5:0] CRFS_PLL2_MULT_HI = 6'h10;

    // compatibility clock rates in kHz
    localparam logic [13:0] CRFS_KHZ_2048 = 14'd2048;
    localparam logic [13:0] CRFS_KHZ_4096 = 14'd4096;
    localparam logic [13:0] CRFS_KHZ_8192 = 14'd8192;

    typedef enum logic [1:0] {
        CRFS_SRC_EXT_REF   = 2'b00,
        CRFS_SRC_RES_DIV   = 2'b01,
        CRFS_SRC_DPLL_2M   = 2'b10,
        CRFS_SRC_DPLL_4M   = 2'b11
    } crfs_src_type;

    typedef enum logic [1:0] {
        CRFS_FB_OSC_DIV4   = 2'b00,
        CRFS_FB_DISABLED   = 2'b01,
        CRFS_FB_SECONDARY  = 2'b10,
        CRFS_FB_RESERVED   = 2'b11
    } crfs_fb_type;

    typedef enum logic [1:0] {
        CRFS_CMP_OFF       = 2'b00,
        CRFS_CMP_2M        = 2'b01,
        CRFS_CMP_4M        = 2'b10,
        CRFS_CMP_8M_SHIFT  = 2'b11
    } crfs_cmp_type;

    localparam logic [2:0] CRFS_SYNC_OSC_DIV4 = 3'b000;

    typedef struct packed {
        crfs_src_type pll1_source_sel;
        logic         pll1_bypass;
        logic [5:0]   pll1_mult;
        logic         pll2_bypass;
        logic [5:0]   pll2_mult;
    } crfs_pll_type;

    typedef struct packed {
        logic         drive_n;
        logic [13:0]  bit_khz;
        logic [13:0]  double_khz;
        logic         double_shifted;
    } crfs_compat_type;

endpackage

// [test/crfs_props.sv]
// checker: bus timing and control-output relations of crfs_top
`timescale 1ns/1ps
module crfs_props
    import crfs_pkg::*;
(
    // clock, reset and bus
    input wire logic            CLOCK,
    input wire logic            RST_N,
    input wire logic            CYC_I,
    input wire logic            STB_I,
    input wire logic            WE_I,
    input wire logic [7:0]      ADR_I,
    input wire logic [3:0]      SEL_I,
    input wire logic [31:0]     DAT_I,
    input wire logic            ACK_O,
    // clocking controls
    input wire crfs_pll_type    PLL_CTRL,
    input wire crfs_compat_type COMPAT_CTRL,
    input wire logic [2:0]      SYNC_SEL,
    input wire logic            FALLBACK_ACTIVE,
    input wire logic            FALLBACK_SM_ENABLE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic req, wr, wr_res, wr_sec;
    assign req    = CYC_I && STB_I && !ACK_O;
    assign wr     = req && WE_I && SEL_I[0];
    assign wr_res = wr && ADR_I[7:2] == CRFS_IDX_RESOURCE[5:0];
    assign wr_sec = wr && ADR_I[7:2] == CRFS_IDX_SECONDARY[5:0];
    AST_ACK_WAIT: assert property (req |=> ACK_O) else $error("ack missing");
    AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O) else $error("ack held");
    AST_PLL1_SRC: assert property (wr_res |=> ##1 FALLBACK_ACTIVE
        || PLL_CTRL.pll1_source_sel == $past(DAT_I[7:6], 2)) else $error("pll1 source");
    AST_PLL1_OPT: assert property (wr_res |=> ##1 PLL_CTRL.pll1_bypass == $past(DAT_I[5], 2)
        && PLL_CTRL.pll1_mult == ($past(DAT_I[4], 2) ? CRFS_PLL1_MULT_HI : CRFS_PLL1_MULT_LO))
        else $error("pll1 options");
    AST_PLL2_OPT: assert property (wr_res |=> ##1 PLL_CTRL.pll2_bypass == $past(DAT_I[3], 2)
        && PLL_CTRL.pll2_mult == ($past(DAT_I[2], 2) ? CRFS_PLL2_MULT_HI : CRFS_PLL2_MULT_LO))
        else $error("pll2 options");
    AST_COMPAT_OFF: assert property (wr_res |=> ##1
        COMPAT_CTRL.drive_n == ($past(DAT_I[1:0], 2) == 2'b00)) else $error("compat enable");
    AST_COMPAT_RATE: assert property (!COMPAT_CTRL.drive_n |-> (COMPAT_CTRL.double_shifted ?
        COMPAT_CTRL.bit_khz == CRFS_KHZ_8192 && COMPAT_CTRL.double_khz == CRFS_KHZ_8192
        : COMPAT_CTRL.double_khz == COMPAT_CTRL.bit_khz << 1)) else $error("compat rate");
    AST_FORCE: assert property (wr_sec && DAT_I[3] |=> ##1 FALLBACK_ACTIVE
        && SYNC_SEL == $past(DAT_I[2:0], 2) && PLL_CTRL.pll1_source_sel == $past(DAT_I[7:6], 2))
        else $error("forced fallback");
    AST_SM_EN: assert property (wr_sec |=> ##1
        FALLBACK_SM_ENABLE == ($past(DAT_I[5:4], 2) == 2'b10)) else $error("state machine enable");
endmodule

// [test/tb_top.sv]
// testbench: register accesses and clock-control output checks for crfs_top
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
    import crfs_pkg::*;
    logic            clock, rst_n, req, we, ack, mfail, abfail;
    logic [7:0]      adr, rd, v;
    logic [3:0]      sel;
    logic [31:0]     dw, dr;
    logic [2:0]      msync, sync;
    logic [1:0]      k;
    logic            fb_act, fb_sm;
    crfs_pll_type    pll;
    crfs_compat_type cmp;
    int              err_total, samples_checked;
    logic [13:0]     bk[4] = '{14'h0, CRFS_KHZ_2048, CRFS_KHZ_4096, CRFS_KHZ_8192};
    logic [13:0]     dk[4] = '{14'h0, CRFS_KHZ_4096, CRFS_KHZ_8192, CRFS_KHZ_8192};
    crfs_top i_dut (.CLOCK(clock), .RST_N(rst_n), .CYC_I(req), .STB_I(req), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dw), .DAT_O(dr), .ACK_O(ack), .MAIN_CLOCK_FAIL(mfail),
        .AB_CLOCK_FAIL(abfail), .MAIN_SYNC_SEL(msync), .PLL_CTRL(pll), .COMPAT_CTRL(cmp),
        .SYNC_SEL(sync), .FALLBACK_ACTIVE(fb_act), .FALLBACK_SM_ENABLE(fb_sm));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one classic cycle; returns two edges after release so registered outputs have settled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        req <= 1'b1;
        we <= w;
        adr <= a;
        dw <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (ack !== 1'b1) begin
            err_total++;
            results();
        end
        rd = dr[7:0];
        req <= 1'b0;
        we <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic fail_pulse(input logic m, input logic b);
        mfail <= m;
        abfail <= b;
        @(posedge clock);
        {mfail, abfail} <= 2'b00;
        repeat (2) @(posedge clock);
    endtask
    initial begin
        {rst_n, req, we, mfail, abfail, adr, dw} = '0;
        sel = 4'h1;
        msync = 3'b011;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        wb(1'b0, 8'h0C, 8'h00);
        `CHK("compat idle", 1'b1, cmp.drive_n)
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            v = {k, k[0], k[1], ~k[0], k[1], k};
            wb(1'b1, 8'h0C, v);
            `CHK("pll1 source", k, pll.pll1_source_sel)
            `CHK("pll1 bypass", k[0], pll.pll1_bypass)
            `CHK("pll1 mult", k[1] ? 6'h20 : 6'h10, pll.pll1_mult)
            `CHK("pll2 bypass", ~k[0], pll.pll2_bypass)
            `CHK("pll2 mult", k[1] ? 6'h10 : 6'h08, pll.pll2_mult)
            `CHK("compat off", k == 2'b00, cmp.drive_n)
            if (k != 2'b00) begin
                `CHK("bit khz", bk[k], cmp.bit_khz)
                `CHK("double khz", dk[k], cmp.double_khz)
                `CHK("shifted", k == 2'b11, cmp.double_shifted)
            end
            wb(1'b0, 8'h0C, 8'h00);
            `CHK("readback", v, rd)
        end
        wb(1'b1, 8'h14, 8'hFF);
        wb(1'b0, 8'h14, 8'h00);
        `CHK("unmapped", 8'h00, rd)
        $display("test resource done");
        // force with fallback type disabled still switches over
        wb(1'b1, 8'h10, 8'h9D);
        `CHK("forced active", 1'b1, fb_act)
        `CHK("forced source", 2'b10, pll.pll1_source_sel)
        `CHK("forced sync", 3'b101, sync)
        wb(1'b1, 8'h10, 8'h22);
        `CHK("sm enable", 1'b1, fb_sm)
        `CHK("no fallback", 1'b0, fb_act)
        `CHK("main sync", msync, sync)
        fail_pulse(1'b0, 1'b1);
        `CHK("ab fallback", 1'b1, fb_act)
        `CHK("ab sync", 3'b010, sync)
        `CHK("ab source", 2'b00, pll.pll1_source_sel)
        wb(1'b0, 8'h20, 8'h00);
        `CHK("status latched", 8'h03, rd)
        wb(1'b1, 8'h20, 8'h02);
        wb(1'b0, 8'h20, 8'h00);
        `CHK("status cleared", 8'h00, rd)
        `CHK("cleared active", 1'b0, fb_act)
        wb(1'b1, 8'h10, 8'h12);
        fail_pulse(1'b1, 1'b1);
        `CHK("type off", 1'b0, fb_act)
        wb(1'b1, 8'h10, 8'h02);
        fail_pulse(1'b1, 1'b0);
        `CHK("osc4 active", 1'b1, fb_act)
        `CHK("osc4 sync", 3'b000, sync)
        `CHK("osc4 source", 2'b11, pll.pll1_source_sel)
        $display("test fallback done");
        results();
    end
endmodule
bind crfs_top crfs_props i_props (.CLOCK(CLOCK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .ACK_O(ACK_O),
    .PLL_CTRL(PLL_CTRL), .COMPAT_CTRL(COMPAT_CTRL), .SYNC_SEL(SYNC_SEL),
    .FALLBACK_ACTIVE(FALLBACK_ACTIVE), .FALLBACK_SM_ENABLE(FALLBACK_SM_ENABLE));
